// File: shared/lcdpi_params.svh
`ifndef LCDPI_PARAMS_SVH
`define LCDPI_PARAMS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define LCDPI_OFF_CTRL       8'h00
`define LCDPI_OFF_STATUS     8'h04
`define LCDPI_OFF_FUNC       8'h08
`define LCDPI_OFF_DISP       8'h0c
`define LCDPI_OFF_ENTRY      8'h10
`define LCDPI_OFF_MEM_ADDR   8'h14
`define LCDPI_OFF_MEM_DATA   8'h18
// ****************************************
// Field positions
// ****************************************
`define LCDPI_CTRL_START     0
`define LCDPI_STAT_BUSY      0
`define LCDPI_STAT_DONE      1
`define LCDPI_FUNC_FONT      0
`define LCDPI_FUNC_LINES     1
`define LCDPI_FUNC_WIDTH     2
`define LCDPI_DISP_BLINK     0
`define LCDPI_DISP_CURSOR    1
`define LCDPI_DISP_ON        2
`define LCDPI_ENTRY_SHIFT    0
`define LCDPI_ENTRY_INC      1
// ****************************************
// Reset values
// ****************************************
`define LCDPI_RST_WIDTH      1'b1
`define LCDPI_RST_LINES      1'b0
`define LCDPI_RST_FONT       1'b0
`define LCDPI_RST_DISP       1'b0
`define LCDPI_RST_INC        1'b1
`define LCDPI_RST_SHIFT      1'b0
`define LCDPI_SPACE_CODE     8'h20
// ****************************************
// Memory size and addressing
// ****************************************
`define LCDPI_MEM_DEPTH      128
`define LCDPI_ADDR_W         7
`define LCDPI_LAST_ADDR      7'h7f
`endif

// File: shared/lcdpi_pkg.sv
package lcdpi_pkg;
  typedef enum logic [2:0] {
    LCDPI_S_IDLE  = 3'b000,
    LCDPI_S_CLEAR = 3'b001,
    LCDPI_S_FUNC  = 3'b010,
    LCDPI_S_DISP  = 3'b011,
    LCDPI_S_ENTRY = 3'b100
  } lcdpi_state_t;
endpackage

// File: src/lcdpi_char_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdpi_params.svh"
module lcdpi_char_mem (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_we,
  input  wire logic [`LCDPI_ADDR_W-1:0]   i_waddr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic [`LCDPI_ADDR_W-1:0]   i_raddr,
  output logic      [7:0]                 o_rdata
);
  // ****************************************
  // Flip-flop storage, no reset: cleared by sequencer
  // ****************************************
  localparam int ADDR_W = `LCDPI_ADDR_W;
  logic [7:0] mem [`LCDPI_MEM_DEPTH];
  genvar g;
  generate
    for (g = 0; g < `LCDPI_MEM_DEPTH; g = g + 1) begin : g_ent
      localparam logic [ADDR_W-1:0] ENT_IDX = ADDR_W'(g);
      logic [7:0] next_ent;
      always_comb begin
        next_ent = mem[g];
        if (i_we && (i_waddr == ENT_IDX)) begin
          next_ent = i_wdata;
        end
      end
      always_ff @(posedge i_clk_sys) begin
        mem[g] <= next_ent;
      end
    end
  endgenerate
  always_ff @(posedge i_clk_sys) begin
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// File: src/lcdpi_power_init.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdpi_params.svh"
// Overview of operation
// - Reset sets bus width select to 1, 8-bit bus mode.
// - Reset clears line count and font bits: one line, 5x8 font.
// - Reset clears display, cursor and blink enables.
// - Reset sets entry direction to increment.
// - Reset clears entry shift bit: no whole-display shift.
// - Busy indication stays high until every default step completes.
// - Initialisation fills all display memory with the space code.
module lcdpi_power_init (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  output logic             o_busy_indication,
  output logic             o_bus_width_sel
);
  // ****************************************
  // Sequencer state
  // ****************************************
  lcdpi_pkg::lcdpi_state_t   state, next_state;
  logic [`LCDPI_ADDR_W-1:0]  clr_addr, next_clr_addr;
  logic                      bus_width_sel, next_bus_width_sel;
  logic                      line_sel, next_line_sel;
  logic                      font_sel, next_font_sel;
  logic                      disp_on, next_disp_on;
  logic                      cursor_on, next_cursor_on;
  logic                      blink_on, next_blink_on;
  logic                      inc_dir, next_inc_dir;
  logic                      shift_en, next_shift_en;
  logic                      done, next_done;
  logic                      busy, next_busy;
  logic                      mem_we;
  logic [`LCDPI_ADDR_W-1:0]  mem_waddr;
  logic [7:0]                mem_wdata;
  logic [7:0]                mem_rdata;
  // ****************************************
  // Bus slave state
  // ****************************************
  logic                      aw_held, next_aw_held;
  logic [7:0]                aw_addr, next_aw_addr;
  logic                      w_held, next_w_held;
  logic [31:0]               w_data, next_w_data;
  logic [3:0]                w_strb, next_w_strb;
  logic                      bvalid, next_bvalid;
  logic [1:0]                bresp, next_bresp;
  logic                      ar_pend, next_ar_pend;
  logic [7:0]                ar_addr, next_ar_addr;
  logic                      rvalid, next_rvalid;
  logic [1:0]                rresp, next_rresp;
  logic [31:0]               rdata, next_rdata;
  logic [`LCDPI_ADDR_W-1:0]  host_addr, next_host_addr;
  logic                      wr_fire;
  logic                      start_req;
  logic [`LCDPI_ADDR_W-1:0]  step;
  always_comb begin
    wr_fire   = aw_held && w_held && !bvalid;
    start_req = wr_fire && (aw_addr == `LCDPI_OFF_CTRL) && w_strb[0] && w_data[`LCDPI_CTRL_START];
    step      = inc_dir ? 7'h01 : 7'h7f;
  end
  // ****************************************
  // Power-on default sequence
  // ****************************************
  always_comb begin
    next_state         = state;
    next_clr_addr      = clr_addr;
    next_bus_width_sel = bus_width_sel;
    next_line_sel      = line_sel;
    next_font_sel      = font_sel;
    next_disp_on       = disp_on;
    next_cursor_on     = cursor_on;
    next_blink_on      = blink_on;
    next_inc_dir       = inc_dir;
    next_shift_en      = shift_en;
    next_done          = done;
    next_busy          = busy;
    mem_we             = 1'b0;
    mem_waddr          = clr_addr;
    mem_wdata          = `LCDPI_SPACE_CODE;
    case (state)
      lcdpi_pkg::LCDPI_S_CLEAR: begin
        mem_we        = 1'b1;
        next_clr_addr = clr_addr + 7'h01;
        if (clr_addr == `LCDPI_LAST_ADDR) begin
          next_state = lcdpi_pkg::LCDPI_S_FUNC;
        end
      end
      lcdpi_pkg::LCDPI_S_FUNC: begin
        next_bus_width_sel = `LCDPI_RST_WIDTH;
        next_line_sel      = `LCDPI_RST_LINES;
        next_font_sel      = `LCDPI_RST_FONT;
        next_state         = lcdpi_pkg::LCDPI_S_DISP;
      end
      lcdpi_pkg::LCDPI_S_DISP: begin
        next_disp_on   = `LCDPI_RST_DISP;
        next_cursor_on = `LCDPI_RST_DISP;
        next_blink_on  = `LCDPI_RST_DISP;
        next_state     = lcdpi_pkg::LCDPI_S_ENTRY;
      end
      lcdpi_pkg::LCDPI_S_ENTRY: begin
        next_inc_dir  = `LCDPI_RST_INC;
        next_shift_en = `LCDPI_RST_SHIFT;
        next_done     = 1'b1;
        next_busy     = 1'b0;
        next_state    = lcdpi_pkg::LCDPI_S_IDLE;
      end
      lcdpi_pkg::LCDPI_S_IDLE: begin
        // Software restart is the host-driven path when reset misbehaves
        if (start_req) begin
          next_state    = lcdpi_pkg::LCDPI_S_CLEAR;
          next_clr_addr = '0;
          next_busy     = 1'b1;
          next_done     = 1'b0;
        end else if (wr_fire && !busy && w_strb[0]) begin
          case (aw_addr)
            `LCDPI_OFF_FUNC: begin
              next_font_sel      = w_data[`LCDPI_FUNC_FONT];
              next_line_sel      = w_data[`LCDPI_FUNC_LINES];
              next_bus_width_sel = w_data[`LCDPI_FUNC_WIDTH];
            end
            `LCDPI_OFF_DISP: begin
              next_blink_on  = w_data[`LCDPI_DISP_BLINK];
              next_cursor_on = w_data[`LCDPI_DISP_CURSOR];
              next_disp_on   = w_data[`LCDPI_DISP_ON];
            end
            `LCDPI_OFF_ENTRY: begin
              next_shift_en = w_data[`LCDPI_ENTRY_SHIFT];
              next_inc_dir  = w_data[`LCDPI_ENTRY_INC];
            end
            `LCDPI_OFF_MEM_DATA: begin
              mem_we    = 1'b1;
              mem_waddr = host_addr;
              mem_wdata = w_data[7:0];
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_state = lcdpi_pkg::LCDPI_S_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      // Reset launches the clear pass; busy is high from the first cycle
      state         <= lcdpi_pkg::LCDPI_S_CLEAR;
      clr_addr      <= '0;
      bus_width_sel <= `LCDPI_RST_WIDTH;
      line_sel      <= `LCDPI_RST_LINES;
      font_sel      <= `LCDPI_RST_FONT;
      disp_on       <= `LCDPI_RST_DISP;
      cursor_on     <= `LCDPI_RST_DISP;
      blink_on      <= `LCDPI_RST_DISP;
      inc_dir       <= `LCDPI_RST_INC;
      shift_en      <= `LCDPI_RST_SHIFT;
      done          <= 1'b0;
      busy          <= 1'b1;
    end else begin
      state         <= next_state;
      clr_addr      <= next_clr_addr;
      bus_width_sel <= next_bus_width_sel;
      line_sel      <= next_line_sel;
      font_sel      <= next_font_sel;
      disp_on       <= next_disp_on;
      cursor_on     <= next_cursor_on;
      blink_on      <= next_blink_on;
      inc_dir       <= next_inc_dir;
      shift_en      <= next_shift_en;
      done          <= next_done;
      busy          <= next_busy;
    end
  end
  lcdpi_char_mem u_mem (
    .i_clk_sys (i_clk_sys),
    .i_we      (mem_we),
    .i_waddr   (mem_waddr),
    .i_wdata   (mem_wdata),
    .i_raddr   (host_addr),
    .o_rdata   (mem_rdata)
  );
  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  always_comb begin
    next_aw_held   = aw_held;
    next_aw_addr   = aw_addr;
    next_w_held    = w_held;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_ar_pend   = ar_pend;
    next_ar_addr   = ar_addr;
    next_rvalid    = rvalid;
    next_rresp     = rresp;
    next_rdata     = rdata;
    next_host_addr = host_addr;
    if (i_s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = i_s_axi_wdata;
      next_w_strb = i_s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = 2'b00;
      // Function, display, entry and memory data writes during busy are dropped with SLVERR so software sees it
      case (aw_addr)
        `LCDPI_OFF_CTRL, `LCDPI_OFF_STATUS: begin
        end
        `LCDPI_OFF_FUNC, `LCDPI_OFF_DISP, `LCDPI_OFF_ENTRY, `LCDPI_OFF_MEM_DATA: begin
          if (busy) begin
            next_bresp = 2'b10;
          end
        end
        `LCDPI_OFF_MEM_ADDR: begin
          if (w_strb[0]) begin
            next_host_addr = w_data[`LCDPI_ADDR_W-1:0];
          end
        end
        default: next_bresp = 2'b11;
      endcase
      if (aw_addr == `LCDPI_OFF_MEM_DATA && !busy && w_strb[0]) begin
        next_host_addr = host_addr + step;
      end
    end
    if (bvalid && i_s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (i_s_axi_arvalid && !ar_pend && !rvalid) begin
      next_ar_pend = 1'b1;
      next_ar_addr = i_s_axi_araddr;
    end
    if (ar_pend) begin
      // One cycle wait lets the memory read port settle
      next_ar_pend = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = 2'b00;
      next_rdata   = 32'h0000_0000;
      case (ar_addr)
        `LCDPI_OFF_CTRL: next_rdata = 32'h0000_0000;
        `LCDPI_OFF_STATUS: begin
          next_rdata[`LCDPI_STAT_BUSY] = busy;
          next_rdata[`LCDPI_STAT_DONE] = done;
        end
        `LCDPI_OFF_FUNC: next_rdata[2:0] = {bus_width_sel, line_sel, font_sel};
        `LCDPI_OFF_DISP: next_rdata[2:0] = {disp_on, cursor_on, blink_on};
        `LCDPI_OFF_ENTRY: next_rdata[1:0] = {inc_dir, shift_en};
        `LCDPI_OFF_MEM_ADDR: next_rdata[`LCDPI_ADDR_W-1:0] = host_addr;
        `LCDPI_OFF_MEM_DATA: next_rdata[7:0] = mem_rdata;
        default: next_rresp = 2'b11;
      endcase
    end
    if (rvalid && i_s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      aw_held   <= 1'b0;
      aw_addr   <= 8'h00;
      w_held    <= 1'b0;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'b00;
      ar_pend   <= 1'b0;
      ar_addr   <= 8'h00;
      rvalid    <= 1'b0;
      rresp     <= 2'b00;
      rdata     <= 32'h0000_0000;
      host_addr <= '0;
    end else begin
      aw_held   <= next_aw_held;
      aw_addr   <= next_aw_addr;
      w_held    <= next_w_held;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      ar_pend   <= next_ar_pend;
      ar_addr   <= next_ar_addr;
      rvalid    <= next_rvalid;
      rresp     <= next_rresp;
      rdata     <= next_rdata;
      host_addr <= next_host_addr;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_s_axi_awready   <= 1'b0;
      o_s_axi_wready    <= 1'b0;
      o_s_axi_arready   <= 1'b0;
      o_busy_indication <= 1'b1;
      o_bus_width_sel   <= `LCDPI_RST_WIDTH;
    end else begin
      o_s_axi_awready   <= i_s_axi_awvalid && !aw_held && !o_s_axi_awready;
      o_s_axi_wready    <= i_s_axi_wvalid && !w_held && !o_s_axi_wready;
      o_s_axi_arready   <= i_s_axi_arvalid && !ar_pend && !rvalid && !o_s_axi_arready;
      o_busy_indication <= next_busy;
      o_bus_width_sel   <= next_bus_width_sel;
    end
  end
  assign o_s_axi_bvalid = bvalid;
  assign o_s_axi_bresp  = bresp;
  assign o_s_axi_rvalid = rvalid;
  assign o_s_axi_rresp  = rresp;
  assign o_s_axi_rdata  = rdata;
endmodule
`default_nettype wire

// File: test/lcdpi_power_init_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdpi_params.svh"
module lcdpi_power_init_sva (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  input  wire logic        o_s_axi_awready,
  input  wire logic        i_s_axi_bready,
  input  wire logic [1:0]  o_s_axi_bresp,
  input  wire logic        o_s_axi_bvalid,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  input  wire logic        o_s_axi_arready,
  input  wire logic [31:0] o_s_axi_rdata,
  input  wire logic        o_s_axi_rvalid,
  input  wire logic        o_busy_indication,
  input  wire logic        o_bus_width_sel
);
  // ****************
  // Access tracking
  // ****************
  logic [7:0] aw_q;
  logic [7:0] ar_q;
  logic       cfg_wr;
  logic       mem_wr;
  logic       rd_idle;
  // Defaults judged only until software overrides them
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      aw_q   <= 8'h00;
      ar_q   <= 8'h00;
      cfg_wr <= 1'b0;
      mem_wr <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) aw_q <= i_s_axi_awaddr;
      if (i_s_axi_arvalid && o_s_axi_arready) ar_q <= i_s_axi_araddr;
      if (o_s_axi_bvalid && i_s_axi_bready && o_s_axi_bresp == 2'b00) begin
        if (aw_q == `LCDPI_OFF_MEM_DATA) mem_wr <= 1'b1;
        else if (aw_q != `LCDPI_OFF_MEM_ADDR) cfg_wr <= 1'b1;
      end
    end
  end
  assign rd_idle = o_s_axi_rvalid && !o_busy_indication;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_busy_hold: assert property ($rose(i_rst_n) |-> o_busy_indication throughout (##128 1'b1))
    else $error("busy dropped early");
  a_busy_end: assert property ($rose(i_rst_n) |-> ##[129:134] !o_busy_indication)
    else $error("busy never released");
  a_width_reset: assert property ($rose(i_rst_n) |-> o_bus_width_sel throughout (##131 1'b1))
    else $error("width select not set");
  a_func_dflt: assert property (rd_idle && ar_q == `LCDPI_OFF_FUNC && !cfg_wr |->
    o_s_axi_rdata[2:0] == 3'b100)
    else $error("function default wrong");
  a_disp_dflt: assert property (rd_idle && ar_q == `LCDPI_OFF_DISP && !cfg_wr |->
    o_s_axi_rdata[2:0] == 3'b000)
    else $error("display default wrong");
  a_entry_dflt: assert property (rd_idle && ar_q == `LCDPI_OFF_ENTRY && !cfg_wr |->
    o_s_axi_rdata[1:0] == 2'b10)
    else $error("entry default wrong");
  a_mem_space: assert property (rd_idle && ar_q == `LCDPI_OFF_MEM_DATA && !mem_wr |->
    o_s_axi_rdata[7:0] == 8'h20)
    else $error("memory not cleared");
  a_wr_busy_err: assert property (o_s_axi_bvalid && o_busy_indication && aw_q == `LCDPI_OFF_FUNC |->
    o_s_axi_bresp == 2'b10)
    else $error("write accepted while busy");
endmodule
bind lcdpi_power_init lcdpi_power_init_sva u_sva (.*);
`default_nettype wire

// File: test/lcdpi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdpi_params.svh"
module lcdpi_host_model (
  input  wire logic        i_clk_sys,
  output logic [7:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic [7:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic [1:0]  i_rresp,
  input  wire logic        i_rvalid,
  output logic             o_rready,
  output logic             o_timeout
);
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready, o_timeout} = '0;
  end
  // Released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk_sys);
    o_awaddr  <= a;
    o_wdata   <= d;
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk_sys);
      if (i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
      if (i_bvalid) break;
    end
    r = i_bresp;
    o_bready <= 1'b0;
    if (n == 50) o_timeout <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge i_clk_sys);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk_sys);
      if (i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr  <= ~a;
      end
      if (i_rvalid) break;
    end
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
    if (n == 50) o_timeout <= 1'b1;
  endtask
  // Host bring-up when the power-on reset cannot be trusted
  task automatic host_init();
    logic [1:0] r;
    wr(`LCDPI_OFF_FUNC, 32'h4, r);
    wr(`LCDPI_OFF_DISP, 32'h0, r);
    wr(`LCDPI_OFF_ENTRY, 32'h2, r);
  endtask
endmodule
`default_nettype wire

// File: test/lcd_power_on_init_defaults_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcdpi_params.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module lcd_power_on_init_defaults_tb;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  wire  logic [7:0]  awaddr, araddr;
  wire  logic [31:0] wdata, rdata;
  wire  logic [1:0]  bresp, rresp;
  wire  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  wire  logic        arvalid, arready, rvalid, rready, busy, width, tmo;
  int          fail_count = 0;
  int          checks = 0;
  logic [31:0] d;
  logic [1:0]  r;
  always #10 i_clk_sys = ~i_clk_sys;
  lcdpi_power_init dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'h1),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_busy_indication(busy), .o_bus_width_sel(width));
  lcdpi_host_model host (.i_clk_sys(i_clk_sys), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
    .o_wdata(wdata), .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid),
    .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready), .o_timeout(tmo));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge i_clk_sys);
    if (n == 400) begin
      fail_count++;
      $display("[FAIL] %0t busy never cleared", $time);
      test_done();
    end
  endtask
  task automatic t_defaults();
    host.rd(`LCDPI_OFF_STATUS, d, r);
    `CHK(d[0], 1'b1)
    host.wr(`LCDPI_OFF_FUNC, 32'h0, r);
    `CHK(r, 2'b10)
    wait_idle();
    host.rd(`LCDPI_OFF_STATUS, d, r);
    `CHK(d, 32'h2)
    host.rd(`LCDPI_OFF_FUNC, d, r);
    `CHK(d, 32'h4)
    `CHK(width, 1'b1)
    host.rd(`LCDPI_OFF_DISP, d, r);
    `CHK(d, 32'h0)
    host.rd(`LCDPI_OFF_ENTRY, d, r);
    `CHK(d, 32'h2)
    $display("t_defaults done");
  endtask
  task automatic t_memory();
    logic [7:0] a [3] = '{8'h00, 8'h40, 8'h7f};
    foreach (a[i]) begin
      host.wr(`LCDPI_OFF_MEM_ADDR, {24'h0, a[i]}, r);
      host.rd(`LCDPI_OFF_MEM_DATA, d, r);
      `CHK(d, 32'h20)
    end
    host.wr(`LCDPI_OFF_MEM_ADDR, 32'h5, r);
    host.wr(`LCDPI_OFF_MEM_DATA, 32'h41, r);
    host.wr(`LCDPI_OFF_MEM_DATA, 32'h42, r);
    host.wr(`LCDPI_OFF_MEM_ADDR, 32'h6, r);
    host.rd(`LCDPI_OFF_MEM_DATA, d, r);
    `CHK(d, 32'h42)
    host.wr(`LCDPI_OFF_ENTRY, 32'h0, r);
    host.wr(`LCDPI_OFF_MEM_ADDR, 32'h10, r);
    host.wr(`LCDPI_OFF_MEM_DATA, 32'h43, r);
    host.wr(`LCDPI_OFF_MEM_DATA, 32'h44, r);
    host.rd(`LCDPI_OFF_MEM_ADDR, d, r);
    `CHK(d, 32'he)
    host.wr(`LCDPI_OFF_MEM_ADDR, 32'hf, r);
    host.rd(`LCDPI_OFF_MEM_DATA, d, r);
    `CHK(d, 32'h44)
    $display("t_memory done");
  endtask
  task automatic t_host_init();
    host.wr(`LCDPI_OFF_FUNC, 32'h3, r);
    host.rd(`LCDPI_OFF_FUNC, d, r);
    `CHK(d, 32'h3)
    `CHK(width, 1'b0)
    host.host_init();
    `CHK(width, 1'b1)
    host.wr(`LCDPI_OFF_DISP, 32'h7, r);
    host.wr(`LCDPI_OFF_CTRL, 32'h1, r);
    host.rd(`LCDPI_OFF_STATUS, d, r);
    `CHK(d[0], 1'b1)
    wait_idle();
    host.rd(`LCDPI_OFF_DISP, d, r);
    `CHK(d, 32'h0)
    host.wr(`LCDPI_OFF_MEM_ADDR, 32'h5, r);
    host.rd(`LCDPI_OFF_MEM_DATA, d, r);
    `CHK(d, 32'h20)
    $display("t_host_init done");
  endtask
  task automatic t_unmapped();
    host.rd(8'h40, d, r);
    `CHK(r, 2'b11)
    host.wr(8'h40, 32'h1, r);
    `CHK(r, 2'b11)
    $display("t_unmapped done");
  endtask
  always @(posedge tmo) begin
    fail_count++;
    $display("[FAIL] %0t bus timeout", $time);
    test_done();
  end
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_defaults();
    t_memory();
    t_host_init();
    t_unmapped();
    test_done();
  end
endmodule
`default_nettype wire
